// ===== core/pmic_ctrl.sv
// power mode sequencer and interrupt flag logic of the analog companion die.
// assumes the microcontroller drives the register port synchronously to
// sys_clk and that the analog comparator outputs arrive already synchronous.
// Function
// - stop entered only with stop bit set and microcontroller halted
// - stop wake from bus or wake input only when enable permits
// - stop wake signalled by interrupt line, not by reset
// - stop wake cause readable in wake input and bus wake flags
// - sleep entered when software sets the sleep bit
// - sleep switches regulator off and holds reset pin low
// - sleep wake unmaskable, acts as power on reset, records cause
// - normal request releases reset, stages off, timeout until power stage on
// - normal mode enables stages and bus, watchdog only when enabled
// - stop and sleep disable stages, watchdog, keep bus recessive with wake
// - each enabled event pulses interrupt line, seven sources maskable
// - all interrupt enables clear after reset
// - undervoltage sets flag, interrupts if enabled, off in stop and sleep
// - overvoltage sets flag, interrupts if enabled, off in stop and sleep
// - overtemperature sets flag, interrupts if enabled, off in stop and sleep
// - in stop, bus rising edge after long dominant sets bus wake flag when its enable is set
// - power stage fault sets flag, interrupts if enabled, off in low power
// - hall state edge sets hall flag in run mode when configured
// - wake input state edge sets wake input flag in run mode
// - flag register eight bits, zero at reset, bit four constant zero
// - writing one clears a flag, zero leaves it, reset clears
// - overtemperature clear ignored while condition persists
// - power stage on bit must be set within timeout else sleep
// - undervoltage and overvoltage clears ignored while condition persists
module pmic_ctrl #(
    parameter int STARTUP_CYC = pmic_pkg::STARTUP_TIMEOUT_CYC
) (
    input  wire logic                      sys_clk,
    input  wire logic                      rstn,
    input  wire pmic_pkg::pmic_reg_req_type reg_req,
    output logic [7:0]                     reg_rdata,
    input  wire pmic_pkg::pmic_events_type events,
    input  wire logic                      mcu_halted,
    input  wire logic                      hall_irq_capable,
    output logic                           irq_out,
    output logic                           irq_oe,
    output logic                           reset_out,
    output logic                           reset_oe,
    output logic                           regulator_on,
    output logic                           regulator_low_current,
    output logic                           power_stage_enable,
    output logic                           bus_enable,
    output logic                           bus_wake_detect,
    output logic                           watchdog_run,
    output pmic_pkg::pmic_mode_type        mode
);

    pmic_pkg::pmic_mode_type mode_reg;
    pmic_pkg::pmic_mode_type mode_next;
    logic [7:0]  flag_reg;
    logic [7:0]  mask_reg;
    logic [3:0]  ctrl_reg;
    logic [1:0]  wake_cause_reg;
    logic [31:0] timeout_reg;
    logic [15:0] dominant_reg;
    logic        bus_dom_long_reg;
    logic        bus_dom_prev_reg;
    logic        hall_prev_reg;
    logic        wake_prev_reg;
    logic [15:0] pulse_reg;
    logic [7:0]  active_prev_reg;
    logic [7:0]  set_vec;
    logic [7:0]  clr_vec;
    logic [7:0]  hold_vec;
    logic [7:0]  active_vec;
    logic        run_mode;
    logic        flag_wr;
    logic        stop_wake;
    logic        sleep_wake;
    logic        wake_edge;
    logic        bus_edge;

    // register write decode, shared by several processes
    function automatic logic reg_write(input pmic_pkg::pmic_reg_req_type r,
                                       input logic [7:0] off);
        reg_write = r.wr && (r.addr == off);
    endfunction

    assign run_mode  = (mode_reg == pmic_pkg::PMIC_NORMAL) ||
                       (mode_reg == pmic_pkg::PMIC_NORMRQ);
    assign flag_wr   = reg_write(reg_req, pmic_pkg::FLAG_REG_OFFSET);
    assign wake_edge = events.wake_input_state_flag ^ wake_prev_reg;
    // bus wake: release after a dominant longer than the filter time
    assign bus_edge  = !events.bus_dominant && bus_dom_prev_reg && bus_dom_long_reg;

    // gated wakes in stop, unmaskable ones in sleep
    assign stop_wake = (mode_reg == pmic_pkg::PMIC_STOP) &&
        ((bus_edge && mask_reg[pmic_pkg::FLAG_BUSWAKE]) ||
         (wake_edge && mask_reg[pmic_pkg::FLAG_WAKE_IN]));
    assign sleep_wake = (mode_reg == pmic_pkg::PMIC_SLEEP) &&
        (bus_edge || wake_edge);

    // flag set sources; comparators only count outside stop and sleep
    always_comb begin
        set_vec = 8'h00;
        set_vec[pmic_pkg::FLAG_UNDERV]  = run_mode && events.undervoltage;
        set_vec[pmic_pkg::FLAG_OVERV]   = run_mode && events.overvoltage;
        set_vec[pmic_pkg::FLAG_OVERTMP] = run_mode && events.overtemp;
        set_vec[pmic_pkg::FLAG_PSFAIL]  = run_mode && events.power_stage_fault;
        set_vec[pmic_pkg::FLAG_HALL]    = run_mode && hall_irq_capable &&
                                          (events.hall_state_flag ^ hall_prev_reg);
        set_vec[pmic_pkg::FLAG_WAKE_IN] = (run_mode && wake_edge) ||
            (stop_wake && wake_edge);
        set_vec[pmic_pkg::FLAG_BUSWAKE] = (mode_reg == pmic_pkg::PMIC_STOP) &&
            mask_reg[pmic_pkg::FLAG_BUSWAKE] && bus_edge;
    end

    // conditions that block write-one clearing while still present
    always_comb begin
        hold_vec = 8'h00;
        hold_vec[pmic_pkg::FLAG_OVERTMP] = events.overtemp;
        hold_vec[pmic_pkg::FLAG_UNDERV]  = events.undervoltage;
        hold_vec[pmic_pkg::FLAG_OVERV]   = events.overvoltage;
    end

    assign clr_vec = flag_wr ? (reg_req.wdata & ~hold_vec) : 8'h00;

    // flag register; set wins over a simultaneous clear
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            flag_reg <= pmic_pkg::REG_RESET;
        end else if (mode_reg == pmic_pkg::PMIC_RESET) begin
            flag_reg <= pmic_pkg::REG_RESET;
        end else begin
            flag_reg <= ((flag_reg & ~clr_vec) | set_vec) & pmic_pkg::FLAG_IMPL_MASK;
        end
    end

    // mask register, cleared by every reset
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mask_reg <= pmic_pkg::REG_RESET;
        end else if (mode_reg == pmic_pkg::PMIC_RESET) begin
            mask_reg <= pmic_pkg::REG_RESET;
        end else if (reg_write(reg_req, pmic_pkg::IMR_OFFSET)) begin
            mask_reg <= reg_req.wdata & pmic_pkg::FLAG_IMPL_MASK;
        end
    end

    // system control; stop and stage bits clear on the way into stop, so
    // only a fresh write of the stage bit brings the die back to normal
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg <= 4'h0;
        end else if (mode_reg == pmic_pkg::PMIC_RESET) begin
            ctrl_reg <= 4'h0;
        end else if (reg_write(reg_req, pmic_pkg::SCR_OFFSET)) begin
            ctrl_reg <= reg_req.wdata[3:0];
        end else if (mode_next == pmic_pkg::PMIC_STOP) begin
            ctrl_reg[pmic_pkg::SCR_STOP]     <= 1'b0;
            ctrl_reg[pmic_pkg::SCR_STAGE_ON] <= 1'b0;
        end
    end

    // sleep wake causes survive the wake reset, write one clears
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wake_cause_reg <= 2'h0;
        end else begin
            wake_cause_reg[pmic_pkg::RSR_BUSWAKE] <= (sleep_wake && bus_edge) ||
                (wake_cause_reg[pmic_pkg::RSR_BUSWAKE] &&
                 !(reg_write(reg_req, pmic_pkg::RSR_OFFSET) &&
                   reg_req.wdata[pmic_pkg::RSR_BUSWAKE]));
            wake_cause_reg[pmic_pkg::RSR_WAKEIN] <= (sleep_wake && wake_edge) ||
                (wake_cause_reg[pmic_pkg::RSR_WAKEIN] &&
                 !(reg_write(reg_req, pmic_pkg::RSR_OFFSET) &&
                   reg_req.wdata[pmic_pkg::RSR_WAKEIN]));
        end
    end

    // mode sequencer
    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            pmic_pkg::PMIC_RESET: begin
                mode_next = pmic_pkg::PMIC_NORMRQ;
            end
            pmic_pkg::PMIC_NORMRQ: begin
                if (ctrl_reg[pmic_pkg::SCR_STAGE_ON]) begin
                    mode_next = pmic_pkg::PMIC_NORMAL;
                end else if (timeout_reg >= 32'(STARTUP_CYC - 1)) begin
                    mode_next = pmic_pkg::PMIC_SLEEP;
                end
            end
            pmic_pkg::PMIC_NORMAL: begin
                if (ctrl_reg[pmic_pkg::SCR_SLEEP]) begin
                    mode_next = pmic_pkg::PMIC_SLEEP;
                end else if (ctrl_reg[pmic_pkg::SCR_STOP] && mcu_halted) begin
                    mode_next = pmic_pkg::PMIC_STOP;
                end
            end
            pmic_pkg::PMIC_STOP: begin
                if (ctrl_reg[pmic_pkg::SCR_SLEEP]) begin
                    mode_next = pmic_pkg::PMIC_SLEEP;
                end else if (ctrl_reg[pmic_pkg::SCR_STAGE_ON]) begin
                    mode_next = pmic_pkg::PMIC_NORMAL;
                end
            end
            pmic_pkg::PMIC_SLEEP: begin
                if (sleep_wake) begin
                    mode_next = pmic_pkg::PMIC_RESET;
                end
            end
            default: begin
                mode_next = pmic_pkg::PMIC_RESET;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mode_reg <= pmic_pkg::PMIC_RESET;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // startup confirmation timer, only counts in normal request
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            timeout_reg <= 32'h0;
        end else if (mode_reg == pmic_pkg::PMIC_NORMRQ) begin
            timeout_reg <= timeout_reg + 32'h1;
        end else begin
            timeout_reg <= 32'h0;
        end
    end

    // bus dominant filter; measures dominant length for the wake edge
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            dominant_reg     <= 16'h0;
            bus_dom_long_reg <= 1'b0;
            bus_dom_prev_reg <= 1'b0;
        end else begin
            bus_dom_prev_reg <= events.bus_dominant;
            if (!events.bus_dominant) begin
                dominant_reg     <= 16'h0;
                bus_dom_long_reg <= 1'b0;
            end else if (dominant_reg >= 16'(pmic_pkg::BUS_FILTER_CYC)) begin
                bus_dom_long_reg <= 1'b1;
            end else begin
                dominant_reg <= dominant_reg + 16'h1;
            end
        end
    end

    // previous state of hall and wake input, for edge detection
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            hall_prev_reg <= 1'b0;
            wake_prev_reg <= 1'b0;
        end else begin
            hall_prev_reg <= events.hall_state_flag;
            wake_prev_reg <= events.wake_input_state_flag;
        end
    end

    // interrupt pulse: restarts on any newly active enabled flag
    assign active_vec = flag_reg & mask_reg;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            active_prev_reg <= 8'h00;
            pulse_reg       <= 16'h0;
        end else begin
            active_prev_reg <= active_vec;
            if ((active_vec & ~active_prev_reg) != 8'h00) begin
                pulse_reg <= 16'(pmic_pkg::IRQ_PULSE_CYC);
            end else if (pulse_reg != 16'h0) begin
                pulse_reg <= pulse_reg - 16'h1;
            end
        end
    end

    // pin and enable outputs, all registered
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq_out               <= 1'b0;
            irq_oe                <= 1'b0;
            reset_out             <= 1'b0;
            reset_oe              <= 1'b1;
            regulator_on          <= 1'b1;
            regulator_low_current <= 1'b0;
            power_stage_enable    <= 1'b0;
            bus_enable            <= 1'b0;
            bus_wake_detect       <= 1'b0;
            watchdog_run          <= 1'b0;
            mode                  <= pmic_pkg::PMIC_RESET;
        end else begin
            irq_out   <= 1'b0;
            irq_oe    <= (pulse_reg != 16'h0);
            reset_out <= 1'b0;
            reset_oe  <= (mode_next == pmic_pkg::PMIC_RESET) ||
                         (mode_next == pmic_pkg::PMIC_SLEEP);
            regulator_on          <= (mode_next != pmic_pkg::PMIC_SLEEP);
            regulator_low_current <= (mode_next == pmic_pkg::PMIC_STOP);
            power_stage_enable    <= (mode_next == pmic_pkg::PMIC_NORMAL);
            bus_enable            <= (mode_next == pmic_pkg::PMIC_NORMAL);
            bus_wake_detect       <= (mode_next == pmic_pkg::PMIC_STOP) ||
                                     (mode_next == pmic_pkg::PMIC_SLEEP);
            watchdog_run          <= (mode_next == pmic_pkg::PMIC_NORMAL) &&
                                     ctrl_reg[pmic_pkg::SCR_WDEN];
            mode                  <= mode_next;
        end
    end

    // register read mux, registered; unmapped reads zero
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_req.rd) begin
            case (reg_req.addr)
                pmic_pkg::FLAG_REG_OFFSET: reg_rdata <= flag_reg;
                pmic_pkg::IMR_OFFSET:      reg_rdata <= mask_reg;
                pmic_pkg::SCR_OFFSET:      reg_rdata <= {4'h0, ctrl_reg};
                pmic_pkg::RSR_OFFSET:      reg_rdata <= {6'h0, wake_cause_reg};
                default:                   reg_rdata <= 8'h00;
            endcase
        end
    end

    // assertions
    a_bit4_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
        flag_reg[4] == 1'b0) else $error("flag bit four set");
    a_stop_entry: assert property (@(posedge sys_clk) disable iff (!rstn)
        (mode_reg == pmic_pkg::PMIC_NORMAL && mode_next == pmic_pkg::PMIC_STOP)
        |-> mcu_halted) else $error("stop without halt");
    a_sleep_reset: assert property (@(posedge sys_clk) disable iff (!rstn)
        (mode_reg == pmic_pkg::PMIC_SLEEP) |-> (reset_oe && !regulator_on))
        else $error("sleep outputs wrong");
    a_overtmp_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
        (flag_reg[pmic_pkg::FLAG_OVERTMP] && events.overtemp &&
         mode_reg != pmic_pkg::PMIC_RESET) |=> flag_reg[pmic_pkg::FLAG_OVERTMP])
        else $error("overtemp flag lost");
    // a wake bit that was not yet active must always produce a fresh pulse
    a_stop_irq_wake: assert property (@(posedge sys_clk) disable iff (!rstn)
        (stop_wake && !active_vec[pmic_pkg::FLAG_BUSWAKE] &&
         !active_vec[pmic_pkg::FLAG_WAKE_IN]) |-> ##[1:3] irq_oe)
        else $error("stop wake no irq");
    a_lowpwr_quiet: assert property (@(posedge sys_clk) disable iff (!rstn)
        (mode_reg == pmic_pkg::PMIC_STOP) |-> ##1 (!power_stage_enable || mode_reg !=
         pmic_pkg::PMIC_STOP)) else $error("stages on in stop");
    a_timeout_sleep: assert property (@(posedge sys_clk) disable iff (!rstn)
        (mode_reg == pmic_pkg::PMIC_NORMRQ && timeout_reg >= 32'(STARTUP_CYC - 1) &&
         !ctrl_reg[pmic_pkg::SCR_STAGE_ON]) |=> mode_reg == pmic_pkg::PMIC_SLEEP)
        else $error("no failsafe sleep");
    a_mask_reset: assert property (@(posedge sys_clk) disable iff (!rstn)
        (mode_reg == pmic_pkg::PMIC_RESET) |=> mask_reg == 8'h00)
        else $error("mask not cleared");
    // a newly active enabled flag, the start of every interrupt pulse
    sequence s_irq_new;
        (active_vec & ~active_prev_reg) != 8'h00;
    endsequence
    a_irq_pulse: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_irq_new |-> ##2 irq_oe) else $error("no interrupt pulse");

endmodule

// ===== core/pmic_pkg.sv
// package for the power mode and interrupt controller: register offsets,
// flag bit positions, reset values, timing constants, modes and carriers.
// assumes a 250 MHz die clock and a simple internal register port.
package pmic_pkg;

    // register offsets on the internal register port
    localparam logic [7:0] FLAG_REG_OFFSET = 8'h0A; // interrupt flag register
    localparam logic [7:0] IMR_OFFSET  = 8'h09; // interrupt mask register
    localparam logic [7:0] SCR_OFFSET  = 8'h0C; // system control register
    localparam logic [7:0] RSR_OFFSET  = 8'h0D; // reset status (wake bits only here)

    // interrupt flag and enable bit positions
    localparam int FLAG_WAKE_IN = 7;
    localparam int FLAG_HALL    = 6;
    localparam int FLAG_BUSWAKE = 5;
    localparam int FLAG_OVERTMP = 3;
    localparam int FLAG_UNDERV  = 2;
    localparam int FLAG_OVERV   = 1;
    localparam int FLAG_PSFAIL  = 0;
    localparam logic [7:0] FLAG_IMPL_MASK = 8'hEF; // bit 4 reads zero

    // system control bit positions
    localparam int SCR_STAGE_ON = 0;
    localparam int SCR_STOP  = 1;
    localparam int SCR_SLEEP = 2;
    localparam int SCR_WDEN  = 3;

    // reset status wake bit positions
    localparam int RSR_BUSWAKE = 0;
    localparam int RSR_WAKEIN  = 1;

    localparam logic [7:0] REG_RESET = 8'h00;

    // timing, figures as printed
    localparam int CLK_MHZ             = 250;
    localparam int STARTUP_TIMEOUT_MS  = 80;
    localparam int STARTUP_TIMEOUT_CYC = STARTUP_TIMEOUT_MS * 1000 * CLK_MHZ;
    localparam int BUS_FILTER_NS       = 30000;
    localparam int BUS_FILTER_CYC      = (BUS_FILTER_NS * CLK_MHZ + 999) / 1000;
    localparam int IRQ_PULSE_NS        = 1000;
    localparam int IRQ_PULSE_CYC       = (IRQ_PULSE_NS * CLK_MHZ) / 1000;

    typedef enum logic [2:0] {
        PMIC_RESET  = 3'b000,
        PMIC_NORMRQ = 3'b001,
        PMIC_NORMAL = 3'b010,
        PMIC_STOP   = 3'b011,
        PMIC_SLEEP  = 3'b100
    } pmic_mode_type;

    // analog event inputs from the die
    typedef struct packed {
        logic undervoltage;
        logic overvoltage;
        logic overtemp;
        logic power_stage_fault;
        logic hall_state_flag;
        logic wake_input_state_flag;
        logic bus_dominant;
    } pmic_events_type;

    // register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pmic_reg_req_type;

endpackage

// ===== sim/pmic_mcu_model.sv
// microcontroller model: register port master, halt line and the
// pulled-up interrupt and reset wires; assumes the bench's sys_clk.
module pmic_mcu_model (
    input  wire logic               sys_clk,
    input  wire logic [7:0]         reg_rdata,
    input  wire logic               irq_out,
    input  wire logic               irq_oe,
    input  wire logic               reset_out,
    input  wire logic               reset_oe,
    output pmic_pkg::pmic_reg_req_type reg_req,
    output logic                    mcu_halted,
    output int                      irq_cnt,
    output logic                    rst_line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic irq_line;
    logic irq_prev;

    // open-drain wires fall back to their pull-ups when released
    assign irq_line = irq_oe ? irq_out : 1'b1;
    assign rst_line = reset_oe ? reset_out : 1'b1;

    initial begin
        reg_req = '0;
        mcu_halted = 1'b0;
        irq_cnt = 0;
        irq_prev = 1'b1;
    end

    // each falling edge of the line is one interrupt request
    always @(posedge sys_clk) begin
        if (irq_prev && !irq_line) irq_cnt <= irq_cnt + 1;
        irq_prev <= irq_line;
    end

    // one-cycle access; idle address and data flip so stale values never look valid
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        @(negedge sys_clk);
        reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge sys_clk);
        q = reg_rdata;
        reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule

// ===== sim/power_mode_and_interrupt_ctrl_tb.sv
// self-checking bench for the mode sequencer and interrupt flags.
// assumes a shortened startup timeout and the microcontroller model.
module power_mode_and_interrupt_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STARTUP = 200;
    localparam logic [7:0] FLG = pmic_pkg::FLAG_REG_OFFSET;
    localparam logic [7:0] IMR = pmic_pkg::IMR_OFFSET;
    localparam logic [7:0] SCR = pmic_pkg::SCR_OFFSET;
    typedef struct packed {
        logic [6:0] ev;
        logic [7:0] flag;
        logic [7:0] clr;
        logic [7:0] held;
    } pmic_row_type;
    logic sys_clk, rstn, hall_cap, irq_out, irq_oe, reset_out, reset_oe, rst_line;
    logic reg_on, reg_low, pse, bus_en, bwd, wd_run, halted;
    logic [6:0] ev_bits;
    logic [7:0] rdata;
    pmic_pkg::pmic_reg_req_type req;
    pmic_pkg::pmic_mode_type mode;
    int irq_cnt, n, n_fail, total_checks, cycles;
    pmic_row_type rows[6] = '{'{7'h40, 8'h04, 8'h04, 8'h04}, '{7'h20, 8'h02, 8'h02, 8'h02},
        '{7'h10, 8'h08, 8'h08, 8'h08}, '{7'h08, 8'h01, 8'h00, 8'h01},
        '{7'h04, 8'h40, 8'h40, 8'h00}, '{7'h02, 8'h80, 8'h80, 8'h00}};

    pmic_ctrl #(.STARTUP_CYC(STARTUP)) i_dut (.sys_clk(sys_clk), .rstn(rstn),
        .reg_req(req), .reg_rdata(rdata), .events(pmic_pkg::pmic_events_type'(ev_bits)),
        .mcu_halted(halted), .hall_irq_capable(hall_cap), .irq_out(irq_out),
        .irq_oe(irq_oe), .reset_out(reset_out), .reset_oe(reset_oe), .regulator_on(reg_on),
        .regulator_low_current(reg_low), .power_stage_enable(pse), .bus_enable(bus_en),
        .bus_wake_detect(bwd), .watchdog_run(wd_run), .mode(mode));
    pmic_mcu_model i_mcu (.sys_clk(sys_clk), .reg_rdata(rdata), .irq_out(irq_out),
        .irq_oe(irq_oe), .reset_out(reset_out), .reset_oe(reset_oe), .reg_req(req),
        .mcu_halted(halted), .irq_cnt(irq_cnt), .rst_line(rst_line));

    // 250 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic end_of_test();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // hang guard, far above the expected run of about 17300 cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        i_mcu.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        i_mcu.xfer(1'b0, a, 8'h00, q);
        chk(nm, e, q);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge sys_clk);
    endtask
    task automatic mchk(input pmic_pkg::pmic_mode_type m);
        chk("mode", {5'h00, m}, {5'h00, mode});
    endtask
    // mode outputs packed, bits outside m are left open by the rules
    task automatic ochk(input logic [7:0] e, input logic [7:0] m);
        chk("outputs", e, m & {reg_on, reg_low, pse, bus_en, bwd, wd_run, reset_oe, irq_oe});
    endtask

    // main sequence: reset, timeout, event table, then mode cases
    initial begin
        rstn = 1'b0;
        ev_bits = 7'h00;
        hall_cap = 1'b1;
        cycles = 0;
        cyc(20);
        mchk(pmic_pkg::PMIC_RESET);
        ochk(8'h82, 8'hFF);
        rstn = 1'b1;
        cyc(2);
        mchk(pmic_pkg::PMIC_NORMRQ);
        ochk(8'h80, 8'hF7);
        rd("flags reset", FLG, 8'h00);
        rd("mask reset", IMR, 8'h00);
        rd("unmapped", 8'h3F, 8'h00);
        cyc(STARTUP);
        mchk(pmic_pkg::PMIC_SLEEP);
        ochk(8'h0A, 8'hBF);
        ev_bits = 7'h02;
        cyc(4);
        mchk(pmic_pkg::PMIC_NORMRQ);
        rd("wake cause", pmic_pkg::RSR_OFFSET, 8'h02);
        ev_bits = 7'h00;
        cyc(2);
        wr(FLG, 8'hFF);
        wr(SCR, 8'h09);
        cyc(3);
        mchk(pmic_pkg::PMIC_NORMAL);
        ochk(8'hB4, 8'hF7);
        // event sources: set, pulse, clear while held, clear after
        foreach (rows[i]) begin
            wr(IMR, rows[i].flag);
            n = irq_cnt;
            ev_bits = rows[i].ev;
            cyc(8);
            rd("flag set", FLG, rows[i].flag);
            chk("irq pulse", 8'(n + 1), 8'(irq_cnt));
            wr(FLG, rows[i].clr);
            rd("held clear", FLG, rows[i].held);
            ev_bits = 7'h00;
            cyc(300);
            rd("after drop", FLG, rows[i].flag);
            wr(FLG, 8'hFF);
            rd("cleared", FLG, 8'h00);
        end
        wr(IMR, 8'h00);
        n = irq_cnt;
        ev_bits = 7'h40;
        cyc(8);
        rd("masked flag", FLG, 8'h04);
        chk("masked irq", 8'(n), 8'(irq_cnt));
        ev_bits = 7'h00;
        wr(FLG, 8'hFF);
        // hall input not configured for interrupts: both edges ignored
        hall_cap = 1'b0;
        ev_bits = 7'h04;
        cyc(4);
        ev_bits = 7'h00;
        cyc(4);
        rd("hall unconfigured", FLG, 8'h00);
        hall_cap = 1'b1;
        wr(SCR, 8'h0B);
        cyc(4);
        mchk(pmic_pkg::PMIC_NORMAL);
        i_mcu.mcu_halted = 1'b1;
        cyc(4);
        mchk(pmic_pkg::PMIC_STOP);
        ochk(8'hC8, 8'hFF);
        ev_bits = 7'h40;
        cyc(8);
        ev_bits = 7'h00;
        rd("stop undervolt", FLG, 8'h00);
        // bus wake twice: masked first, then enabled
        for (int k = 0; k < 2; k++) begin
            wr(IMR, k ? 8'h20 : 8'h00);
            n = irq_cnt;
            ev_bits = 7'h01;
            cyc(pmic_pkg::BUS_FILTER_CYC + 10);
            ev_bits = 7'h00;
            cyc(8);
            rd("bus wake", FLG, k ? 8'h20 : 8'h00);
            chk("wake irq", 8'(n + k), 8'(irq_cnt));
            chk("reset line", 8'h01, {7'h00, rst_line});
            mchk(pmic_pkg::PMIC_STOP);
        end
        // wake input edge in stop, enabled
        wr(IMR, 8'h80);
        wr(FLG, 8'hFF);
        ev_bits = 7'h02;
        cyc(8);
        ev_bits = 7'h00;
        rd("stop wake input", FLG, 8'h80);
        mchk(pmic_pkg::PMIC_STOP);
        i_mcu.mcu_halted = 1'b0;
        wr(SCR, 8'h01);
        cyc(4);
        mchk(pmic_pkg::PMIC_NORMAL);
        // watchdog off now; the wake pulse may still be running
        ochk(8'hB0, 8'hF6);
        wr(SCR, 8'h04);
        cyc(4);
        mchk(pmic_pkg::PMIC_SLEEP);
        ochk(8'h0A, 8'hBE);
        end_of_test();
    end
endmodule
